// *** hdl/cmpg_pkg.sv ***
// constants for the complementary waveform generator
package cmpg_pkg;
  localparam int unsigned SYS_HZ = 200_000_000;
  localparam int unsigned OSC_HZ = 8_000_000;
  localparam logic [4:0] OSC_LAST = 5'(SYS_HZ / OSC_HZ - 1);
  localparam logic [4:0] INS_LAST = 5'h03;
  localparam logic [4:0] SYS_LAST = 5'h00;
  localparam int CNT_W = 4;
  localparam int SEL_W = 3;
  localparam int N_SRC = 8;
  localparam int ADDR_W = 8;
  localparam logic [1:0] CS_OSC = 2'h0;
  localparam logic [1:0] CS_INS = 2'h1;
  localparam logic [7:0] REG_CTL0 = 8'h00;
  localparam logic [7:0] REG_CTL1 = 8'h04;
  localparam logic [7:0] REG_DBAND = 8'h08;
  localparam logic [7:0] REG_BLANK = 8'h0C;
  localparam logic [7:0] REG_PHASE = 8'h10;
  localparam logic [7:0] REG_ASD = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam logic [7:0] MSK_CTL0 = 8'h7F;
  localparam logic [7:0] MSK_NIB = 8'h0F;
  localparam logic [7:0] MSK_ASD = 8'h7F;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int C0_EN = 0, C0_CS = 1, C0_POL0 = 3, C0_POL1 = 4;
  localparam int C0_OE0 = 5, C0_OE1 = 6;
  localparam int C1_RS = 0, C1_RSIM = 3, C1_FS = 4, C1_FSIM = 7;
  localparam int NIB_LO = 0, NIB_HI = 4;
  localparam int AS_EN = 0, AS_ARE = 1, AS_OV0 = 2, AS_OV1 = 3, AS_SRC = 4;
  localparam int ST_SD = 0, ST_ON = 1, ST_O0 = 2, ST_O1 = 3;
  localparam int ST_LR = 4, ST_LF = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int D_PH = 0, D_DBR = 1, D_DBF = 2, D_BLR = 3, D_BLF = 4;
  localparam int N_DLY = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
endpackage

// *** hdl/cmpg_evdet.sv ***
// event input synchroniser with pending edge capture
`timescale 1ns/100ps
`default_nettype none
module cmpg_evdet
  import cmpg_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic src, // selected source
  input wire logic fall_det, // 1: detect high-to-low
  input wire logic tick, // generator clock tick
  output logic lvl, // synchronised level
  output logic pend // edge seen since last tick
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pend;
  } cmpg_ev_t;
  cmpg_ev_t s, n;
  logic edge_seen;

  ////////////////////////////////////////////////////////////////////
  assign edge_seen = fall_det ? (s.prev & ~s.s2) : (~s.prev & s.s2);
  assign lvl = s.s2;
  assign pend = s.pend | edge_seen;

  always_comb begin
    n = s;
    n.s1 = src;
    n.s2 = s.s1;
    n.prev = s.s2;
    n.pend = (s.pend | edge_seen) & ~tick;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

// *** hdl/cmpg_delay.sv ***
// generator-clock counter for phase, dead band and blanking
`timescale 1ns/100ps
`default_nettype none
module cmpg_delay
  import cmpg_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic tick, // generator clock tick
  input wire logic start, // begin counting
  input wire logic clr, // abandon count
  input wire logic [cmpg_pkg::CNT_W-1:0] lim, // count, nonzero
  output logic busy, // counting
  output logic done // last tick of count
);
  typedef struct packed {
    logic busy;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;
  } cmpg_dly_t;
  cmpg_dly_t s, n;

  ////////////////////////////////////////////////////////////////////
  assign busy = s.busy;
  assign done = s.busy & tick & (s.cnt == s.last);

  always_comb begin
    n = s;
    if (clr) begin
      n.busy = 1'b0;
    end else if (start) begin
      n.busy = 1'b1;
      n.cnt = CNT_ZERO;
      n.last = lim - CNT_ONE;
    end else if (s.busy && tick) begin
      if (s.cnt == s.last) begin
        n.busy = 1'b0;
      end else begin
        n.cnt = s.cnt + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  chk_start_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (start && !clr) |=> busy) else $error("counter did not start");
  chk_done_ends: assert property (@(posedge clk) disable iff (!rst_n)
    (done && !start) |=> !busy) else $error("counter ran past its count");
endmodule
`default_nettype wire

// *** hdl/cmpg_top.sv ***
// complementary waveform generator with AXI4-Lite registers
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module cmpg_top
  import cmpg_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic [cmpg_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [cmpg_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [cmpg_pkg::N_SRC-1:0] ev_src, // event and fault sources
  input wire logic limit_timer, // limit timer output
  output logic drive_out_primary, // primary pin level
  output logic drive_out_primary_oe_n, // primary pin enable, low drives
  output logic drive_out_complement, // complement pin level
  output logic drive_out_complement_oe_n // complement enable, low drives
);
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] dband;
    logic [7:0] blank;
    logic [7:0] phase;
    logic [7:0] asd;
    logic [4:0] div;
    logic tick;
    logic f1;
    logic f2;
    logic sd;
    logic on;
    logic o0;
    logic o1;
    logic p0;
    logic p1;
    logic oe0_n;
    logic oe1_n;
  } cmpg_top_t;
  cmpg_top_t s, n;

  logic [N_SRC-1:0] src_vec;
  logic ena, pol0, pol1, ovr0, ovr1, rmode, fmode;
  logic [1:0] cs;
  logic [CNT_W-1:0] ph_n, dbr_n, dbf_n, blr_n, blf_n;
  logic lvl_r, pend_r, lvl_f, pend_f;
  logic rise_hit, fall_hit, rise_go, wr_do, sw_clr;
  logic [N_DLY-1:0] d_start, d_clr, d_busy, d_done;
  logic [CNT_W-1:0] d_lim [N_DLY];

  ////////////////////////////////////////////////////////////////////
  // field views of the control registers
  assign ena = s.ctl0[C0_EN];
  assign cs = s.ctl0[C0_CS +: 2];
  assign pol0 = s.ctl0[C0_POL0];
  assign pol1 = s.ctl0[C0_POL1];
  assign ovr0 = s.asd[AS_OV0];
  assign ovr1 = s.asd[AS_OV1];
  assign rmode = s.ctl1[C1_RSIM];
  assign fmode = s.ctl1[C1_FSIM];
  assign ph_n = s.phase[NIB_LO +: CNT_W];
  assign dbr_n = s.dband[NIB_LO +: CNT_W];
  assign dbf_n = s.dband[NIB_HI +: CNT_W];
  assign blr_n = s.blank[NIB_LO +: CNT_W];
  assign blf_n = s.blank[NIB_HI +: CNT_W];
  assign src_vec = {ev_src[N_SRC-1] | limit_timer, ev_src[N_SRC-2:0]};

  ////////////////////////////////////////////////////////////////////
  // event inputs
  cmpg_evdet u_rise (
    .clk(clk),
    .rst_n(rst_n),
    .src(src_vec[s.ctl1[C1_RS +: SEL_W]]),
    .fall_det(1'b0),
    .tick(s.tick),
    .lvl(lvl_r),
    .pend(pend_r)
  );

  cmpg_evdet u_fall (
    .clk(clk),
    .rst_n(rst_n),
    .src(src_vec[s.ctl1[C1_FS +: SEL_W]]),
    .fall_det(1'b1),
    .tick(s.tick),
    .lvl(lvl_f),
    .pend(pend_f)
  );

  ////////////////////////////////////////////////////////////////////
  // phase, dead band and blanking counters
  assign d_lim[D_PH] = ph_n;
  assign d_lim[D_DBR] = dbr_n;
  assign d_lim[D_DBF] = dbf_n;
  assign d_lim[D_BLR] = blr_n;
  assign d_lim[D_BLF] = blf_n;

  for (genvar i = 0; i < N_DLY; i++) begin : g_dly
    cmpg_delay u_dly (
      .clk(clk),
      .rst_n(rst_n),
      .tick(s.tick),
      .start(d_start[i]),
      .clr(d_clr[i]),
      .lim(d_lim[i]),
      .busy(d_busy[i]),
      .done(d_done[i])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // event decisions, taken on generator clock ticks
  assign rise_hit = s.tick & ena & ~s.sd & ~d_busy[D_BLF] & ~d_busy[D_PH]
    & (rmode ? (lvl_r & ~s.on) : pend_r);
  assign fall_hit = s.tick & ena & ~s.sd & ~d_busy[D_BLR]
    & (fmode ? (~lvl_f & s.on) : pend_f);
  assign rise_go = ena & ~s.sd & ~fall_hit
    & ((rise_hit & (ph_n == CNT_ZERO)) | d_done[D_PH]);
  assign wr_do = ~s.awrdy & ~s.wrdy & ~s.bvalid;
  assign sw_clr = wr_do & (s.waddr == REG_STAT) & s.wstrb0 & s.wdata[ST_SD];

  always_comb begin
    n = s;
    d_start = '0;
    d_clr = '0;
    // generator clock tick
    if (s.div >= (cs == CS_OSC ? OSC_LAST : cs == CS_INS ? INS_LAST : SYS_LAST)) begin
      n.tick = 1'b1;
      n.div = 5'h00;
    end else begin
      n.tick = 1'b0;
      n.div = s.div + 5'h01;
    end
    // waveform core
    if (!ena) begin
      n.on = 1'b0;
      n.o0 = 1'b0;
      n.o1 = 1'b1;
      d_clr = '1;
    end else if (s.sd) begin
      n.on = 1'b0;
      n.o0 = 1'b0;
      n.o1 = 1'b0;
      d_clr = '1;
    end else if (fall_hit) begin
      n.on = 1'b0;
      n.o0 = 1'b0;
      d_clr[D_PH] = 1'b1;
      d_clr[D_DBR] = 1'b1; // overlap: primary suppressed
      d_start[D_BLF] = (blf_n != CNT_ZERO);
      if (dbf_n == CNT_ZERO) begin
        n.o1 = 1'b1;
      end else begin
        d_start[D_DBF] = 1'b1;
      end
    end else begin
      if (rise_hit) begin
        n.on = 1'b1;
        d_start[D_PH] = (ph_n != CNT_ZERO);
      end
      if (d_done[D_DBR]) begin
        n.o0 = 1'b1;
      end
      if (d_done[D_DBF]) begin
        n.o1 = 1'b1;
      end
      if (rise_go) begin
        n.o1 = 1'b0;
        d_clr[D_DBF] = 1'b1; // overlap: complement suppressed
        d_start[D_BLR] = (blr_n != CNT_ZERO);
        if (dbr_n == CNT_ZERO) begin
          n.o0 = 1'b1;
        end else begin
          d_start[D_DBR] = 1'b1;
        end
      end
    end
    // fault shutdown, set wins over release
    n.f1 = src_vec[s.asd[AS_SRC +: SEL_W]];
    n.f2 = s.f1; // second stage reads only the first
    if (s.asd[AS_EN] && s.f2) begin
      n.sd = 1'b1;
    end else if (s.sd && ((s.asd[AS_ARE] && !s.f2) || sw_clr || !s.asd[AS_EN])) begin
      n.sd = 1'b0;
      n.o1 = 1'b1;
    end
    // pins
    if (!ena || s.sd) begin
      n.p0 = ovr0;
      n.p1 = ovr1;
    end else begin
      n.p0 = s.o0 ^ pol0;
      n.p1 = s.o1 ^ pol1;
    end
    n.oe0_n = ~s.ctl0[C0_OE0];
    n.oe1_n = ~s.ctl0[C0_OE1];
    // bus write channel
    if (s.awrdy && s_axi_awvalid) begin
      n.awrdy = 1'b0;
      n.waddr = s_axi_awaddr;
    end
    if (s.wrdy && s_axi_wvalid) begin
      n.wrdy = 1'b0;
      n.wdata = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (wr_do) begin
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (s.waddr)
        REG_CTL0: if (s.wstrb0) n.ctl0 = s.wdata & MSK_CTL0;
        REG_CTL1: if (s.wstrb0) n.ctl1 = s.wdata;
        REG_DBAND: if (s.wstrb0) n.dband = s.wdata;
        REG_BLANK: if (s.wstrb0) n.blank = s.wdata;
        REG_PHASE: if (s.wstrb0) n.phase = s.wdata & MSK_NIB;
        REG_ASD: if (s.wstrb0) n.asd = s.wdata & MSK_ASD;
        REG_STAT: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.awrdy = 1'b1;
      n.wrdy = 1'b1;
    end
    // bus read channel
    if (s.arrdy && s_axi_arvalid) begin
      n.arrdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTL0: n.rdata = 32'(s.ctl0);
        REG_CTL1: n.rdata = 32'(s.ctl1);
        REG_DBAND: n.rdata = 32'(s.dband);
        REG_BLANK: n.rdata = 32'(s.blank);
        REG_PHASE: n.rdata = 32'(s.phase);
        REG_ASD: n.rdata = 32'(s.asd);
        REG_STAT: n.rdata = 32'({lvl_f, lvl_r, s.o1, s.o0, s.on, s.sd});
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arrdy = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.awrdy <= 1'b1;
      s.wrdy <= 1'b1;
      s.arrdy <= 1'b1;
      s.oe0_n <= 1'b1;
      s.oe1_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready = s.awrdy;
  assign s_axi_wready = s.wrdy;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arrdy;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign drive_out_primary = s.p0;
  assign drive_out_primary_oe_n = s.oe0_n;
  assign drive_out_complement = s.p1;
  assign drive_out_complement_oe_n = s.oe1_n;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_no_overlap: assert property (!(s.o0 && s.o1))
    else $error("both drives active");
  chk_fall_clears: assert property (fall_hit |=> !s.o0)
    else $error("primary kept after falling event");
  chk_rise_clears: assert property (rise_go |=> !s.o1)
    else $error("complement kept after rising event");
  chk_zero_dband: assert property ((rise_go && dbr_n == CNT_ZERO) |=> s.o0)
    else $error("primary not immediate");
  chk_enable_idle: assert property (!ena |=> (!s.o0 && s.o1))
    else $error("wrong idle drive state");
  chk_sd_override: assert property ((ena && s.sd) |=>
    (drive_out_primary == $past(ovr0) && !s.o0))
    else $error("shutdown override not applied");
  chk_pol_map: assert property ((ena && !s.sd) |=>
    drive_out_complement == $past(s.o1 ^ pol1))
    else $error("polarity mapping wrong");
  chk_sys_tick: assert property ((cs != CS_OSC && cs != CS_INS) |=> s.tick)
    else $error("system clock tick missing");
  chk_fall_blank: assert property ((rise_go && blr_n != CNT_ZERO) |=> !fall_hit)
    else $error("falling input not blanked");
  chk_b_hold: assert property ((s.bvalid && !s_axi_bready) |=>
    (s.bvalid && $stable(s.bresp))) else $error("write response dropped");
  chk_r_hold: assert property ((s.rvalid && !s_axi_rready) |=>
    (s.rvalid && $stable(s.rdata))) else $error("read data dropped");

  cov_rise: cover property (rise_go ##[1:40] fall_hit);
  cov_rf_overlap: cover property (fall_hit && d_busy[D_DBR]);
  cov_phase: cover property (d_done[D_PH]);
  cov_shutdown: cover property ($rose(s.sd) ##[1:40] $fell(s.sd));
endmodule
`default_nettype wire

// *** tb/cmpg_pwm_src.sv ***
// periodic event source standing in for the pwm unit on the far side
`timescale 1ns/100ps
`default_nettype none
module cmpg_pwm_src #(
  parameter int PER = 40,
  parameter int HI = 20
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic run, // produce pulses
  output logic wave // event source level
);
  int cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 0;
      wave <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
      wave <= run && (cnt_q < HI);
    end
  end
endmodule
`default_nettype wire

// *** tb/cmpg_top_tb.sv ***
// self-checking bench for the complementary waveform generator
`timescale 1ns/100ps
`default_nettype none
module cmpg_top_tb;
  import cmpg_pkg::*;
  localparam int PER = 40;
  localparam int HI = 20;
  localparam int LIM = 400;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic run = 1'b0;
  logic limit_timer = 1'b0;
  logic [31:0] wdata = '0;
  logic [6:0] flt = '0;
  logic awready, wready, bvalid, arready, rvalid, wave, p_out, p_oe_n, c_out, c_oe_n;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata, rd_q;
  int n_errors = 0;
  int n_compared = 0;
  int ovl = 0;
  int w, n, k, m;

  always #2.5 clk = ~clk;
  // both switches on at once would short the bridge
  always @(posedge clk) if (p_out && c_out && !p_oe_n && !c_oe_n) ovl++;

  cmpg_pwm_src #(.PER(PER), .HI(HI)) src_i (.clk(clk), .rst_n(rst_n), .run(run), .wave(wave));
  cmpg_top uut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ev_src({flt, wave}), .limit_timer(limit_timer), .drive_out_primary(p_out),
    .drive_out_primary_oe_n(p_oe_n), .drive_out_complement(c_out),
    .drive_out_complement_oe_n(c_oe_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic tmo(input int cnt);
    if (cnt >= LIM) begin
      n_errors++;
      $display("[ERR] %0t wait ran out", $time);
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < LIM; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    last_resp = bresp;
    bready <= 1'b0;
    tmo(k);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < LIM; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_q = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    tmo(k);
  endtask

  // count edges until the chosen pin reaches level v
  task automatic wt(input logic s, input logic v, output int cnt);
    for (cnt = 1; cnt < LIM; cnt++) begin
      @(posedge clk);
      if ((s ? c_out : p_out) === v) break;
    end
    tmo(cnt);
  endtask

  // skip one pulse, then width and following gap of the next
  task automatic meas(input logic s, output int hi_w, output int lo_w);
    wt(s, 1'b1, n);
    wt(s, 1'b0, n);
    wt(s, 1'b1, n);
    wt(s, 1'b0, hi_w);
    wt(s, 1'b1, lo_w);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(REG_CTL0);
    chk(rd_q, 32'h0, "ctl0 reset");
    wr(REG_CTL1, 8'hA5);
    rd(REG_CTL1);
    chk(rd_q, 32'hA5, "ctl1 readback");
    rd(8'h1C);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h1C, 8'hFF);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    wr(REG_CTL1, 8'h00);
  endtask

  task automatic t_outputs;
    wr(REG_CTL0, 8'h65);
    repeat (4) @(posedge clk);
    chk({p_oe_n, c_oe_n, p_out, c_out}, 32'h1, "enabled idle levels");
    wr(REG_CTL0, 8'h7D);
    repeat (4) @(posedge clk);
    chk({p_out, c_out}, 32'h2, "inverted idle levels");
    wr(REG_CTL0, 8'h7C);
    repeat (4) @(posedge clk);
    chk({p_out, c_out}, 32'h0, "override ignores polarity");
  endtask

  task automatic t_pwm;
    wr(REG_CTL0, 8'h65);
    run <= 1'b1;
    meas(1'b0, w, m);
    chk(w, HI, "primary width");
    chk(w + m, PER, "primary period");
    for (int md = 0; md < 4; md++) begin
      wr(REG_CTL1, {md[1], 3'h0, md[0], 3'h0});
      meas(1'b0, w, m);
      chk(w, HI, "width per input mode");
    end
    wr(REG_CTL1, 8'h00);
  endtask

  task automatic t_delays;
    wr(REG_DBAND, 8'h33);
    meas(1'b0, w, m);
    chk(w, HI - 3, "rise dead band");
    meas(1'b1, w, m);
    chk(w, PER - HI - 3, "fall dead band");
    wr(REG_DBAND, 8'h00);
    wr(REG_PHASE, 8'h04);
    meas(1'b0, w, m);
    chk(w, HI - 4, "phase delay");
    wr(REG_PHASE, 8'h00);
    wr(REG_CTL0, 8'h63);
    wr(REG_DBAND, 8'h02);
    meas(1'b0, w, m);
    chk(w, HI - 8, "dead band on instruction clock");
    wr(REG_DBAND, 8'h00);
    wr(REG_CTL0, 8'h65);
  endtask

  task automatic t_limit;
    wr(REG_CTL1, 8'h70);
    wt(1'b0, 1'b1, n);
    limit_timer <= 1'b1;
    repeat (4) @(posedge clk);
    limit_timer <= 1'b0;
    wt(1'b0, 1'b0, n);
    chk(n < 12, 32'h1, "limit timer ends drive");
    wr(REG_CTL1, 8'h00);
  endtask

  task automatic t_shutdown;
    wr(REG_ASD, 8'h15);
    wt(1'b0, 1'b1, n);
    flt[0] <= 1'b1;
    repeat (8) @(posedge clk);
    chk({p_out, c_out}, 32'h2, "shutdown override levels");
    rd(REG_STAT);
    chk(rd_q[0], 32'h1, "shutdown flag");
    flt[0] <= 1'b0;
    wr(REG_STAT, 8'h01);
    wr(REG_ASD, 8'h00);
    meas(1'b0, w, m);
    chk(w, HI, "drive resumes");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_outputs();
    t_pwm();
    t_delays();
    t_limit();
    t_shutdown();
    chk(ovl, 32'h0, "outputs overlap");
    close_out();
  end
endmodule
`default_nettype wire
